//--- src/ttt_pkg.sv
// Shared constants and types for the trail trace transmitter
package ttt_pkg;
  // Register port geometry
  localparam int ADDR_W = 8;
  localparam int DATA_W = 16;
  // Register byte addresses
  localparam logic [7:0] OFS_CONTROL = 8'he8;
  localparam logic [7:0] OFS_POINTER = 8'hea;
  localparam logic [7:0] OFS_DATA = 8'hec;
  // Control field positions
  localparam int BIT_LSB_FIRST = 0;
  localparam int BIT_INVERT = 1;
  localparam int BIT_ALL_ZERO = 2;
  localparam int BIT_ALIGN_DIS = 3;
  localparam int CTRL_W = 4;
  // Identifier store geometry
  localparam int PTR_W = 4;
  localparam int BYTE_W = 8;
  localparam int ID_BYTES = 16;
  localparam int CNT_W = 3;
  // Reset values
  localparam logic [CTRL_W-1:0] RST_CONTROL = 4'h0;
  localparam logic [PTR_W-1:0] RST_POINTER = 4'h0;
  localparam logic [BYTE_W-1:0] RST_ID_BYTE = 8'h00;
  localparam logic [DATA_W-1:0] RST_RDATA = 16'h0000;
  // Alignment bit carried by the first byte, zero on the others
  localparam logic ALIGN_MARK = 1'b1;

  // Whole state of the transmitter
  typedef struct packed {
    logic [CTRL_W-1:0] control;                  // Control bits
    logic [PTR_W-1:0] id_byte_pointer;           // Software byte pointer
    logic [ID_BYTES-1:0][BYTE_W-1:0] id_store;   // Identifier bytes
    logic [DATA_W-1:0] rdata;                    // Read data holding
    logic [PTR_W-1:0] tx_index;                  // Byte being sent
    logic [CNT_W-1:0] tx_count;                  // Bit within byte
  } ttt_state_s;

  // Buffer state: head slot and skid slot
  typedef struct packed {
    logic head_v;
    logic head_d;
    logic skid_v;
    logic skid_d;
  } ttt_buf_s;
endpackage

//--- src/ttt_stream_if.sv
// Valid/ready bit stream between the serializer and its buffer
`timescale 1ns/1ps
`default_nettype none
interface ttt_stream_if #(parameter int WIDTH = 1);
  logic valid;              // Word offered
  logic ready;              // Word accepted when valid
  logic [WIDTH-1:0] data;   // Word content
  modport src (output valid, output data, input ready);
  modport snk (input valid, input data, output ready);
endinterface
`default_nettype wire

//--- src/ttt_buffer.sv
// Two-entry buffer with registered head output
`timescale 1ns/1ps
`default_nettype none
module ttt_buffer import ttt_pkg::*; (
  input wire logic i_clk,
  input wire logic i_rst,
  ttt_stream_if.snk in_s,
  ttt_stream_if.src out_s
);
  ttt_buf_s s_r;    // Registered state
  ttt_buf_s s_nxt;  // Next state

  // Head feeds the output directly so the pins come off flops
  assign out_s.valid = s_r.head_v;
  assign out_s.data = s_r.head_d;
  // Only a full skid slot refuses input, so a stall costs no word
  assign in_s.ready = ~s_r.skid_v;

  // Pop then push
  always_comb begin
    s_nxt = s_r;
    // Drain head, refill from skid
    if (s_r.head_v && out_s.ready) begin
      if (s_r.skid_v) begin
        s_nxt.head_d = s_r.skid_d;
        s_nxt.skid_v = 1'b0;
      end else begin
        s_nxt.head_v = 1'b0;
      end
    end
    // Take new word into first free slot
    if (in_s.valid && !s_r.skid_v) begin
      if (!s_nxt.head_v) begin
        s_nxt.head_v = 1'b1;
        s_nxt.head_d = in_s.data;
      end else begin
        s_nxt.skid_v = 1'b1;
        s_nxt.skid_d = in_s.data;
      end
    end
  end

  // State register
  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Stalled head must hold its word
  head_hold_a: assert property (@(posedge i_clk) disable iff (i_rst)
    s_r.head_v && !out_s.ready |=> s_r.head_v && s_r.head_d == $past(s_r.head_d))
    else $error("buffer head changed while stalled");
endmodule
`default_nettype wire

//--- src/ttt_transmitter.sv
// Trail trace transmitter: identifier store, register port, serializer
//
// Function
// - Alignment bit replaces first bit when enabled
// - Alignment disabled: bytes sent unmodified
// - All-zero control sends zero bytes apart from the alignment bit
// - Inversion control inverts every outgoing bit
// - Default order sends bit 7 first
// - Reorder control sends bit 0 first
// - Four-bit pointer selects data access byte
// - Each data access advances pointer, wraps
// - Data register reads/writes pointed byte
`timescale 1ns/1ps
`default_nettype none
module ttt_transmitter import ttt_pkg::*; (
  input wire logic I_SYS_CLK,
  input wire logic I_RST,
  input wire logic [ADDR_W-1:0] I_ADDR,
  input wire logic I_WR_EN,
  input wire logic I_RD_EN,
  input wire logic [DATA_W-1:0] I_WDATA,
  output logic [DATA_W-1:0] O_RDATA,
  output logic O_TT_VALID,
  output logic O_TT_BIT,
  input wire logic I_TT_READY
);
  ttt_state_s s_r;    // Registered state
  ttt_state_s s_nxt;  // Next state

  ttt_stream_if #(.WIDTH(1)) ser_s();  // Serializer to buffer
  ttt_stream_if #(.WIDTH(1)) out_s();  // Buffer to pins

  logic align_insert_disable;  // Control fields
  logic send_all_zero;
  logic output_invert_en;
  logic lsb_first_en;
  logic data_access;           // Any access to the data register
  logic [BYTE_W-1:0] cur_byte; // Byte before alignment overwrite
  logic tx_bit;                // Bit offered to the buffer
  logic push;                  // Bit taken by the buffer
  // Declared ahead of the bit selection that reads it
  logic multiframe_align_bit;  // Alignment bit of current byte

  // Position inside the byte for a given bit slot
  function automatic logic [CNT_W-1:0] bit_pos(input logic [CNT_W-1:0] cnt,
                                               input logic lsb);
    bit_pos = lsb ? cnt : (CNT_W'(BYTE_W - 1) - cnt);
  endfunction

  // Alignment bit value for a byte slot
  function automatic logic align_bit(input logic [PTR_W-1:0] idx);
    align_bit = (idx == '0) ? ALIGN_MARK : ~ALIGN_MARK;
  endfunction

  assign align_insert_disable = s_r.control[BIT_ALIGN_DIS];
  assign send_all_zero = s_r.control[BIT_ALL_ZERO];
  assign output_invert_en = s_r.control[BIT_INVERT];
  assign lsb_first_en = s_r.control[BIT_LSB_FIRST];
  assign data_access = (I_WR_EN || I_RD_EN) && I_ADDR == OFS_DATA;
  assign push = ser_s.valid && ser_s.ready;

  // Outgoing bit selection
  always_comb begin
    // Idle replaces the byte but still carries the alignment bit
    cur_byte = send_all_zero ? RST_ID_BYTE : s_r.id_store[s_r.tx_index];
    tx_bit = cur_byte[bit_pos(s_r.tx_count, lsb_first_en)];
    if (!align_insert_disable && s_r.tx_count == '0) begin
      tx_bit = multiframe_align_bit;
    end
    // Inversion is the last step before the line
    tx_bit = tx_bit ^ output_invert_en;
  end

  // Only the first byte of the sequence carries a one
  assign multiframe_align_bit = align_bit(s_r.tx_index);

  // Serializer never idles; the buffer paces it
  assign ser_s.valid = 1'b1;
  assign ser_s.data = tx_bit;

  ttt_buffer u_buffer (
    .i_clk(I_SYS_CLK),
    .i_rst(I_RST),
    .in_s(ser_s.snk),
    .out_s(out_s.src)
  );

  assign out_s.ready = I_TT_READY;
  // Both come from the buffer's head flops
  assign O_TT_VALID = out_s.valid;
  assign O_TT_BIT = out_s.data;
  assign O_RDATA = s_r.rdata;

  // Register port and serializer stepping
  always_comb begin
    s_nxt = s_r;
    // Writes; reserved bits are dropped
    if (I_WR_EN) begin
      case (I_ADDR)
        OFS_CONTROL: s_nxt.control = I_WDATA[CTRL_W-1:0];
        OFS_POINTER: s_nxt.id_byte_pointer = I_WDATA[PTR_W-1:0];
        OFS_DATA: s_nxt.id_store[s_r.id_byte_pointer] = I_WDATA[BYTE_W-1:0];
        default: ;
      endcase
    end
    // Reads are registered; unmapped addresses answer zero
    if (I_RD_EN) begin
      case (I_ADDR)
        OFS_CONTROL: s_nxt.rdata = DATA_W'(s_r.control);
        OFS_POINTER: s_nxt.rdata = DATA_W'(s_r.id_byte_pointer);
        OFS_DATA: s_nxt.rdata = DATA_W'(s_r.id_store[s_r.id_byte_pointer]);
        default: s_nxt.rdata = RST_RDATA;
      endcase
    end
    // One step per access even when read and write coincide
    if (data_access) begin
      s_nxt.id_byte_pointer = s_r.id_byte_pointer + PTR_W'(1);
    end
    // Advance bit and byte once the buffer takes the bit
    if (push) begin
      s_nxt.tx_count = s_r.tx_count + CNT_W'(1);
      if (s_r.tx_count == CNT_W'(BYTE_W - 1)) begin
        s_nxt.tx_index = s_r.tx_index + PTR_W'(1);
      end
    end
  end

  // State register
  always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
    if (I_RST) begin
      s_r.control <= RST_CONTROL;
      s_r.id_byte_pointer <= RST_POINTER;
      s_r.id_store <= '0;
      s_r.rdata <= RST_RDATA;
      s_r.tx_index <= '0;
      s_r.tx_count <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Alignment bit lands on the first bit of each byte
  align_insert_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && !align_insert_disable && s_r.tx_count == '0
      |-> tx_bit == (align_bit(s_r.tx_index) ^ output_invert_en))
    else $error("alignment bit missing on first bit");

  // Stored bytes pass untouched when insertion is off
  raw_byte_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && align_insert_disable && !send_all_zero
      |-> tx_bit == (s_r.id_store[s_r.tx_index][bit_pos(s_r.tx_count, lsb_first_en)]
                     ^ output_invert_en))
    else $error("stored byte altered with insertion off");

  // Idle sends zeros apart from the alignment slot
  idle_zero_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && send_all_zero && (align_insert_disable || s_r.tx_count != '0)
      |-> tx_bit == output_invert_en)
    else $error("idle bit not zero");

  // Inversion flips the line bit
  invert_out_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && output_invert_en && align_insert_disable && send_all_zero |-> tx_bit)
    else $error("inverted idle bit not one");

  // Most significant bit leads
  msb_first_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && s_r.tx_count == 3'h1 && !lsb_first_en && !send_all_zero && !output_invert_en
      |-> tx_bit == s_r.id_store[s_r.tx_index][6])
    else $error("msb-first order broken");

  // Least significant bit leads
  lsb_first_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && s_r.tx_count == 3'h1 && lsb_first_en && !send_all_zero && !output_invert_en
      |-> tx_bit == s_r.id_store[s_r.tx_index][1])
    else $error("lsb-first order broken");

  // Pointer write is taken as written
  ptr_load_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    I_WR_EN && I_ADDR == OFS_POINTER
      |=> s_r.id_byte_pointer == $past(I_WDATA[PTR_W-1:0]))
    else $error("pointer write lost");

  // Data access moves pointer by one with wrap
  ptr_step_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    data_access |=> s_r.id_byte_pointer == $past(s_r.id_byte_pointer) + 4'h1)
    else $error("pointer did not advance");

  // Data read returns the pointed byte
  data_read_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    I_RD_EN && I_ADDR == OFS_DATA
      |=> O_RDATA == {8'h00, $past(s_r.id_store[s_r.id_byte_pointer])})
    else $error("data read wrong byte");

  // Byte slot steps after the eighth bit
  byte_order_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && s_r.tx_count == 3'h7 |=> s_r.tx_index == $past(s_r.tx_index) + 4'h1)
    else $error("byte order broken");

  // Pointer rests unless an access of its own moves it
  ptr_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !data_access && !(I_WR_EN && I_ADDR == OFS_POINTER)
      |=> $stable(s_r.id_byte_pointer))
    else $error("pointer moved without access");

  // Written byte lands at the pointed location
  store_write_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    I_WR_EN && I_ADDR == OFS_DATA
      |=> s_r.id_store[$past(s_r.id_byte_pointer)] == $past(I_WDATA[BYTE_W-1:0]))
    else $error("data write not stored");

  // A stalled serializer keeps its bit and byte slot, so no bit is skipped
  count_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    !push |=> $stable(s_r.tx_count) && $stable(s_r.tx_index))
    else $error("serializer moved while stalled");

  // Byte slot holds inside a byte
  index_hold_a: assert property (@(posedge I_SYS_CLK) disable iff (I_RST)
    push && s_r.tx_count != 3'h7 |=> $stable(s_r.tx_index))
    else $error("byte slot moved inside a byte");
endmodule
`default_nettype wire

//--- tb/ttt_sink.sv
// Framer-side model that takes trail trace bits from the transmitter
`timescale 1ns/1ps
`default_nettype none
module ttt_sink (
  input wire logic i_clk,
  input wire logic i_accept,
  input wire logic i_valid,
  input wire logic i_bit,
  output logic o_ready,
  output logic o_taken,
  output logic o_bit
);
  // Ready follows the bench's stall choice; a stall may come at any cycle
  assign o_ready = i_accept;
  // A bit counts only when offered and accepted at the same edge
  assign o_taken = i_valid & o_ready;
  // Bit handed on to the bench for comparison
  assign o_bit = i_bit;
endmodule
`default_nettype wire

//--- tb/tb_ttt_transmitter.sv
// Self-checking testbench for the trail trace transmitter
`timescale 1ns/1ps
`default_nettype none
module tb_ttt_transmitter;
  import ttt_pkg::*;
  logic clk = 1'b0; // System clock
  logic rst = 1'b1; // Reset, active high
  logic [ADDR_W-1:0] addr = '0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [DATA_W-1:0] wdata = '0;
  logic [DATA_W-1:0] rdata;
  logic valid, tbit, ready, taken, got;
  logic accept = 1'b0; // Framer stall control
  logic [BYTE_W-1:0] ids [ID_BYTES]; // Mirror of identifier store
  logic [CTRL_W-1:0] ctl_m = '0; // Mirror of control
  logic [DATA_W-1:0] rq [$]; // Expected read data, oldest first
  logic rd_seen = 1'b0; // Read taken at last edge
  logic [ADDR_W-1:0] ra [4] = '{OFS_CONTROL, OFS_POINTER, OFS_DATA, 8'hee};
  int bad_count = 0;
  int compares = 0;
  int skip = 0; // Bits computed under old settings
  int idx = 0;
  int slot = 0;
  int cyc = 0;
  logic [31:0] rs = 32'h3355; // Random state

  ttt_transmitter dut (.I_SYS_CLK(clk), .I_RST(rst), .I_ADDR(addr), .I_WR_EN(wr),
    .I_RD_EN(rd), .I_WDATA(wdata), .O_RDATA(rdata), .O_TT_VALID(valid),
    .O_TT_BIT(tbit), .I_TT_READY(ready));
  ttt_sink sink (.i_clk(clk), .i_accept(accept), .i_valid(valid), .i_bit(tbit),
    .o_ready(ready), .o_taken(taken), .o_bit(got));

  // Free-running clock, 10 ns period
  always #5 clk = ~clk;

  // Xorshift step
  function automatic void step();
    rs ^= rs << 13;
    rs ^= rs >> 17;
    rs ^= rs << 5;
  endfunction

  // Expected bit for the current byte and slot
  function automatic logic exp_bit();
    logic [7:0] b;
    logic d;
    b = ctl_m[BIT_ALL_ZERO] ? 8'h00 : ids[idx];
    d = b[ctl_m[BIT_LSB_FIRST] ? slot : 7 - slot];
    if (!ctl_m[BIT_ALIGN_DIS] && slot == 0) begin
      d = (idx == 0) ? ALIGN_MARK : 1'b0;
    end
    return d ^ ctl_m[BIT_INVERT];
  endfunction

  task automatic chk_rd(input logic [DATA_W-1:0] e);
    compares++;
    if (rdata !== e) begin
      bad_count++;
      $display("ERROR %0t: read %h expected %h", $time, rdata, e);
    end
  endtask

  task automatic chk_bit(input logic e);
    compares++;
    if (got !== e) begin
      bad_count++;
      $display("ERROR %0t: bit %b expected %b", $time, got, e);
    end
  endtask

  task automatic chk_vld(input logic e);
    compares++;
    if (valid !== e) begin
      bad_count++;
      $display("ERROR %0t: valid %b expected %b", $time, valid, e);
    end
  endtask

  // One register access, strobe held for a single cycle
  task automatic acc(input logic [ADDR_W-1:0] a, input logic w, input logic [DATA_W-1:0] d);
    @(negedge clk);
    addr = a;
    wr = w;
    rd = !w;
    wdata = d;
    @(negedge clk);
    wr = 1'b0;
    rd = 1'b0;
  endtask

  // Read with its expectation noted first
  task automatic rdx(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
    rq.push_back(e);
    acc(a, 1'b0, '0);
  endtask

  task automatic summarize();
    if (bad_count == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  // Read data shows in the cycle after the edge that took the read
  always @(posedge clk) rd_seen <= rd;
  always @(negedge clk) begin
    if (rd_seen) begin
      chk_rd(rq.pop_front());
    end
  end

  // Stream watcher and hang guard
  always @(posedge clk) begin
    cyc++;
    if (!rst && taken) begin
      // Buffered bits from before a change are not judged
      if (skip > 0) skip--;
      else chk_bit(exp_bit());
      slot = (slot + 1) % 8;
      if (slot == 0) idx = (idx + 1) % ID_BYTES;
    end
    // Ceiling well above the cycles the scenarios need
    if (cyc == 20000) begin
      bad_count++;
      summarize();
    end
  end

  initial begin
    foreach (ids[i]) ids[i] = '0;
    repeat (6) @(posedge clk);
    @(negedge clk);
    // Outputs at rest while reset is held
    chk_vld(1'b0);
    chk_rd(RST_RDATA);
    rst = 1'b0;
    // Reset values, and an unmapped place reading zero
    foreach (ra[i]) rdx(ra[i], '0);
    // Load all bytes from pointer zero, reserved bits set
    acc(OFS_POINTER, 1'b1, 16'hfff0);
    for (int i = 0; i < ID_BYTES; i++) begin
      step();
      ids[i] = rs[7:0];
      acc(OFS_DATA, 1'b1, {8'hff, ids[i]});
    end
    rdx(OFS_POINTER, 16'h0000);
    for (int i = 0; i < ID_BYTES; i++) rdx(OFS_DATA, {8'h00, ids[i]});
    // Reads past the top wrap the pointer
    acc(OFS_POINTER, 1'b1, 16'hfffe);
    rdx(OFS_POINTER, 16'h000e);
    rdx(OFS_DATA, {8'h00, ids[14]});
    rdx(OFS_DATA, {8'h00, ids[15]});
    rdx(OFS_POINTER, 16'h0000);
    // Every control setting with random framer stalls
    for (int c = 0; c < 16; c++) begin
      @(negedge clk);
      accept = 1'b0;
      repeat (2) @(negedge clk);
      // Stalled framer: buffer full, a bit still offered
      chk_vld(1'b1);
      acc(OFS_CONTROL, 1'b1, {12'hfff, c[3:0]});
      ctl_m = c[3:0];
      skip = 2;
      rdx(OFS_CONTROL, {12'h000, c[3:0]});
      repeat (300) begin
        @(negedge clk);
        step();
        accept = rs[0];
      end
    end
    summarize();
  end
endmodule
`default_nettype wire
